/* File: hdl/rpsc_pkg.sv */
// Purpose: shared constants for the remote position/speed command block
// Assumes: 16-bit remote words, 8-bit register address, 32-bit register data
// Notes: register offsets are byte addresses of aligned words
package rpsc_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_SPEED_MAX = 8'h04;
  localparam logic [7:0] REG_ENTRY_MAX = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] REG_POSITION = 8'h1C;
  // ==========================================================
  // field layout
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_TWO_STN_BIT = 2;
  localparam int ST_POS_DONE_BIT = 0;
  localparam int ST_SPD_DONE_BIT = 1;
  localparam int ST_VALID_BIT = 2;
  localparam int ST_FWD_BIT = 3;
  localparam int ST_REV_BIT = 4;
  localparam int ST_RESP_LSB = 16;
  localparam int EV_ACCEPT = 0;
  localparam int EV_RANGE_ERR = 1;
  localparam int EV_EARLY_START = 2;
  localparam int EV_W = 3;
  // ==========================================================
  // reset values and limits
  localparam logic [15:0] SPEED_MAX_RST = 16'h1000;
  localparam logic [15:0] ENTRY_MAX_RST = 16'h00FF;
  localparam logic [31:0] POS_LIMIT = 32'h00FFFFFF;
  localparam logic [15:0] RAMP_ENTRY_FIXED = 16'h0001;
  localparam logic [15:0] WORD_SIGN_POS = 16'h0000;
  localparam logic [15:0] WORD_SIGN_NEG = 16'hFFFF;
  // ==========================================================
  // respond word: one nibble per command word, range error code
  localparam logic [3:0] ERR_RANGE = 4'h3;
  localparam int RESP_W4_LSB = 0;
  localparam int RESP_W5_LSB = 4;
  localparam int RESP_W6_LSB = 8;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SRC_TABLE = 2'h0,
    SRC_POS_ENTRY = 2'h1,
    SRC_POS_SPEED = 2'h2,
    SRC_BAD = 2'h3
  } rpsc_src_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CHECK = 2'h1,
    ST_DONE = 2'h2
  } rpsc_state_t;
endpackage

/* File: hdl/rpsc_sync.sv */
// Purpose: two-flop synchroniser for link inputs
// Assumes: input levels stable longer than two clocks
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module rpsc_sync #(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

/* File: hdl/rpsc_range_check.sv */
// Purpose: range check of the command words for each command source
// Assumes: words already synchronised
// Notes: purely combinational; zero result means the command is clean
`timescale 1ns/100ps
module rpsc_range_check (
  input wire rpsc_pkg::rpsc_src_t src_in,
  input wire logic [15:0] w4_in,
  input wire logic [15:0] w5_in,
  input wire logic [15:0] w6_in,
  input wire logic [15:0] entry_max_in,
  input wire logic [15:0] speed_max_in,
  output logic [15:0] resp_out
);
  function automatic logic entry_bad(input logic [15:0] e, input logic [15:0] mx);
    entry_bad = (e == 16'h0000) || (e > mx);
  endfunction

  logic signed [31:0] pos;
  logic pos_bad;
  logic hi_bad;

  always_comb begin
    pos = $signed({w5_in, w4_in});
    pos_bad = (pos > $signed(rpsc_pkg::POS_LIMIT)) || (pos < -$signed(rpsc_pkg::POS_LIMIT));
    // a high half that is pure sign extension blames the low half
    hi_bad = pos_bad && (w5_in != rpsc_pkg::WORD_SIGN_POS) && (w5_in != rpsc_pkg::WORD_SIGN_NEG);
    resp_out = 16'h0000;
    case (src_in)
      rpsc_pkg::SRC_TABLE: begin
        if (entry_bad(w4_in, entry_max_in)) begin
          resp_out[rpsc_pkg::RESP_W4_LSB +: 4] = rpsc_pkg::ERR_RANGE;
        end
      end
      rpsc_pkg::SRC_POS_ENTRY, rpsc_pkg::SRC_POS_SPEED: begin
        if (pos_bad && !hi_bad) begin
          resp_out[rpsc_pkg::RESP_W4_LSB +: 4] = rpsc_pkg::ERR_RANGE;
        end
        if (hi_bad) begin
          resp_out[rpsc_pkg::RESP_W5_LSB +: 4] = rpsc_pkg::ERR_RANGE;
        end
        if (src_in == rpsc_pkg::SRC_POS_ENTRY ? entry_bad(w6_in, entry_max_in)
                                              : (w6_in > speed_max_in)) begin
          resp_out[rpsc_pkg::RESP_W6_LSB +: 4] = rpsc_pkg::ERR_RANGE;
        end
      end
      default: begin
        resp_out = 16'h0000;
      end
    endcase
  end
endmodule

/* File: hdl/rpsc_top.sv */
// Purpose: remote position/speed command handshake of a servo drive
// Assumes: link bits and words arrive asynchronously; words settle before requests
// Notes: software reaches config, limits, status and interrupts over a plain port
// Functional notes
// - accept only when selected and two stations
// - source zero takes a table entry number
// - source one takes position plus entry
// - source two takes position plus speed
// - latch entry, then raise position done
// - bad entry puts error in respond word
// - latched data volatile, lost at reset
// - source one speed, ramps from entry
// - source one latches, raises both done
// - source one errors on halves or entry
// - source two ramps from entry one
// - source two errors on halves or speed
`timescale 1ns/100ps
module rpsc_top (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT,
  input wire logic [15:0] CMD_WORD_POSITION_LOW_OR_ENTRY_IN,
  input wire logic [15:0] CMD_WORD_POSITION_HIGH_IN,
  input wire logic [15:0] CMD_WORD_SPEED_OR_ENTRY_IN,
  input wire logic POSITION_CMD_REQUEST_IN,
  input wire logic SPEED_CMD_REQUEST_IN,
  input wire logic SPECIFYING_SYSTEM_SELECT_IN,
  input wire logic FORWARD_START_BIT_IN,
  input wire logic REVERSE_START_BIT_IN,
  output logic POSITION_DONE_OUT,
  output logic SPEED_DONE_OUT,
  output logic [15:0] RESPOND_ERROR_WORD_OUT,
  output logic CMD_VALID_OUT,
  output logic [31:0] TARGET_POSITION_OUT,
  output logic [15:0] TARGET_ENTRY_OUT,
  output logic [15:0] TARGET_SPEED_OUT,
  output logic [15:0] RAMP_ENTRY_OUT,
  output logic FORWARD_RUN_OUT,
  output logic REVERSE_RUN_OUT
);
  // ==========================================================
  // link synchronisers
  logic [15:0] w4_s;
  logic [15:0] w5_s;
  logic [15:0] w6_s;
  logic [4:0] bits_s;
  logic pos_req_s;
  logic spd_req_s;
  logic sel_s;
  logic fwd_s;
  logic rev_s;

  rpsc_sync #(.W(48)) u_word_sync (
    .mclk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in({CMD_WORD_POSITION_LOW_OR_ENTRY_IN, CMD_WORD_POSITION_HIGH_IN,
           CMD_WORD_SPEED_OR_ENTRY_IN}),
    .q_out({w4_s, w5_s, w6_s})
  );

  rpsc_sync #(.W(5)) u_bit_sync (
    .mclk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in({POSITION_CMD_REQUEST_IN, SPEED_CMD_REQUEST_IN, SPECIFYING_SYSTEM_SELECT_IN,
           FORWARD_START_BIT_IN, REVERSE_START_BIT_IN}),
    .q_out(bits_s)
  );

  assign {pos_req_s, spd_req_s, sel_s, fwd_s, rev_s} = bits_s;

  // ==========================================================
  // software registers
  rpsc_pkg::rpsc_src_t src_reg;
  logic two_stn_reg;
  logic [15:0] speed_max_reg;
  logic [15:0] entry_max_reg;
  logic [rpsc_pkg::EV_W-1:0] irq_stat_reg;
  logic [rpsc_pkg::EV_W-1:0] irq_en_reg;
  logic [rpsc_pkg::EV_W-1:0] ev;
  logic wr_clr;

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      src_reg <= rpsc_pkg::SRC_TABLE;
      two_stn_reg <= 1'b0;
      speed_max_reg <= rpsc_pkg::SPEED_MAX_RST;
      entry_max_reg <= rpsc_pkg::ENTRY_MAX_RST;
      irq_en_reg <= '0;
    end else if (WR_IN) begin
      case (ADDR_IN)
        rpsc_pkg::REG_CONFIG: begin
          src_reg <= rpsc_pkg::rpsc_src_t'(WDATA_IN[rpsc_pkg::CFG_SRC_LSB +: 2]);
          two_stn_reg <= WDATA_IN[rpsc_pkg::CFG_TWO_STN_BIT];
        end
        rpsc_pkg::REG_SPEED_MAX: begin
          speed_max_reg <= WDATA_IN[15:0];
        end
        rpsc_pkg::REG_ENTRY_MAX: begin
          entry_max_reg <= WDATA_IN[15:0];
        end
        rpsc_pkg::REG_IRQ_ENABLE: begin
          irq_en_reg <= WDATA_IN[rpsc_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // set wins over clear so no event is lost
  assign wr_clr = WR_IN && (ADDR_IN == rpsc_pkg::REG_IRQ_CLEAR);

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      irq_stat_reg <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? WDATA_IN[rpsc_pkg::EV_W-1:0] : '0)) | ev;
      IRQ_OUT <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ==========================================================
  // command handshake
  rpsc_pkg::rpsc_state_t st_reg;
  rpsc_pkg::rpsc_src_t mode_reg;
  logic [15:0] chk_code;
  logic req_ok;
  logic reqs_gone;
  logic done_ok;

  rpsc_range_check u_check (
    .src_in(mode_reg),
    .w4_in(w4_s),
    .w5_in(w5_s),
    .w6_in(w6_s),
    .entry_max_in(entry_max_reg),
    .speed_max_in(speed_max_reg),
    .resp_out(chk_code)
  );

  always_comb begin
    req_ok = 1'b0;
    if (sel_s && two_stn_reg) begin
      case (src_reg)
        rpsc_pkg::SRC_TABLE: req_ok = pos_req_s;
        rpsc_pkg::SRC_POS_ENTRY: req_ok = pos_req_s && spd_req_s;
        rpsc_pkg::SRC_POS_SPEED: req_ok = pos_req_s && spd_req_s;
        default: req_ok = 1'b0;
      endcase
    end
  end

  assign reqs_gone = !pos_req_s && !spd_req_s;
  assign done_ok = (mode_reg == rpsc_pkg::SRC_TABLE) ? POSITION_DONE_OUT
                                                   : (POSITION_DONE_OUT && SPEED_DONE_OUT);

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      st_reg <= rpsc_pkg::ST_IDLE;
      mode_reg <= rpsc_pkg::SRC_TABLE;
      POSITION_DONE_OUT <= 1'b0;
      SPEED_DONE_OUT <= 1'b0;
      RESPOND_ERROR_WORD_OUT <= 16'h0000;
    end else begin
      case (st_reg)
        rpsc_pkg::ST_IDLE: begin
          if (req_ok) begin
            mode_reg <= src_reg;
            st_reg <= rpsc_pkg::ST_CHECK;
          end
        end
        rpsc_pkg::ST_CHECK: begin
          RESPOND_ERROR_WORD_OUT <= chk_code;
          POSITION_DONE_OUT <= 1'b1;
          SPEED_DONE_OUT <= (mode_reg != rpsc_pkg::SRC_TABLE);
          st_reg <= rpsc_pkg::ST_DONE;
        end
        rpsc_pkg::ST_DONE: begin
          if (reqs_gone) begin
            POSITION_DONE_OUT <= 1'b0;
            SPEED_DONE_OUT <= 1'b0;
            st_reg <= rpsc_pkg::ST_IDLE;
          end
        end
        default: begin
          st_reg <= rpsc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // flops only: reset stands in for power loss, so nothing survives it
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      CMD_VALID_OUT <= 1'b0;
      TARGET_POSITION_OUT <= 32'h00000000;
      TARGET_ENTRY_OUT <= 16'h0000;
      TARGET_SPEED_OUT <= 16'h0000;
      RAMP_ENTRY_OUT <= 16'h0000;
    end else if (st_reg == rpsc_pkg::ST_CHECK) begin
      CMD_VALID_OUT <= (chk_code == 16'h0000);
      if (chk_code == 16'h0000) begin
        case (mode_reg)
          rpsc_pkg::SRC_TABLE: begin
            TARGET_ENTRY_OUT <= w4_s;
            RAMP_ENTRY_OUT <= w4_s;
          end
          rpsc_pkg::SRC_POS_ENTRY: begin
            TARGET_POSITION_OUT <= {w5_s, w4_s};
            TARGET_ENTRY_OUT <= w6_s;
            RAMP_ENTRY_OUT <= w6_s;
          end
          rpsc_pkg::SRC_POS_SPEED: begin
            TARGET_POSITION_OUT <= {w5_s, w4_s};
            TARGET_SPEED_OUT <= w6_s;
            RAMP_ENTRY_OUT <= rpsc_pkg::RAMP_ENTRY_FIXED;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // start gating and events
  logic fwd_d_reg;
  logic rev_d_reg;
  logic start_rise;

  // a start that beats the done flags is held off and reported
  assign start_rise = (fwd_s && !fwd_d_reg) || (rev_s && !rev_d_reg);

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      fwd_d_reg <= 1'b0;
      rev_d_reg <= 1'b0;
      FORWARD_RUN_OUT <= 1'b0;
      REVERSE_RUN_OUT <= 1'b0;
    end else begin
      fwd_d_reg <= fwd_s;
      rev_d_reg <= rev_s;
      FORWARD_RUN_OUT <= fwd_s && !rev_s && done_ok && CMD_VALID_OUT;
      REVERSE_RUN_OUT <= rev_s && !fwd_s && done_ok && CMD_VALID_OUT;
    end
  end

  always_comb begin
    ev = '0;
    ev[rpsc_pkg::EV_ACCEPT] = (st_reg == rpsc_pkg::ST_CHECK) && (chk_code == 16'h0000);
    ev[rpsc_pkg::EV_RANGE_ERR] = (st_reg == rpsc_pkg::ST_CHECK) && (chk_code != 16'h0000);
    ev[rpsc_pkg::EV_EARLY_START] = start_rise && !done_ok;
  end

  // ==========================================================
  // read port: data stand one cycle after the strobe only
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 32'h00000000;
    end else begin
      RDATA_OUT <= 32'h00000000;
      if (RD_IN) begin
        case (ADDR_IN)
          rpsc_pkg::REG_CONFIG: begin
            RDATA_OUT[rpsc_pkg::CFG_SRC_LSB +: 2] <= src_reg;
            RDATA_OUT[rpsc_pkg::CFG_TWO_STN_BIT] <= two_stn_reg;
          end
          rpsc_pkg::REG_SPEED_MAX: RDATA_OUT[15:0] <= speed_max_reg;
          rpsc_pkg::REG_ENTRY_MAX: RDATA_OUT[15:0] <= entry_max_reg;
          rpsc_pkg::REG_STATUS: begin
            RDATA_OUT[rpsc_pkg::ST_POS_DONE_BIT] <= POSITION_DONE_OUT;
            RDATA_OUT[rpsc_pkg::ST_SPD_DONE_BIT] <= SPEED_DONE_OUT;
            RDATA_OUT[rpsc_pkg::ST_VALID_BIT] <= CMD_VALID_OUT;
            RDATA_OUT[rpsc_pkg::ST_FWD_BIT] <= FORWARD_RUN_OUT;
            RDATA_OUT[rpsc_pkg::ST_REV_BIT] <= REVERSE_RUN_OUT;
            RDATA_OUT[rpsc_pkg::ST_RESP_LSB +: 16] <= RESPOND_ERROR_WORD_OUT;
          end
          rpsc_pkg::REG_IRQ_STATUS: RDATA_OUT[rpsc_pkg::EV_W-1:0] <= irq_stat_reg;
          rpsc_pkg::REG_IRQ_ENABLE: RDATA_OUT[rpsc_pkg::EV_W-1:0] <= irq_en_reg;
          rpsc_pkg::REG_POSITION: RDATA_OUT <= TARGET_POSITION_OUT;
          default: RDATA_OUT <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  accept_gate_a: assert property (
    (st_reg == rpsc_pkg::ST_IDLE) && !(sel_s && two_stn_reg) |=> st_reg == rpsc_pkg::ST_IDLE)
    else $error("command accepted without select and two stations");
  table_latch_a: assert property (
    (st_reg == rpsc_pkg::ST_CHECK) && (mode_reg == rpsc_pkg::SRC_TABLE) && (chk_code == 16'h0000)
    |=> (TARGET_ENTRY_OUT == $past(w4_s)) && CMD_VALID_OUT)
    else $error("table entry not latched");
  pos_entry_latch_a: assert property (
    (st_reg == rpsc_pkg::ST_CHECK) && (mode_reg == rpsc_pkg::SRC_POS_ENTRY) && (chk_code == 16'h0000)
    |=> (TARGET_POSITION_OUT == {$past(w5_s), $past(w4_s)}) && (RAMP_ENTRY_OUT == $past(w6_s)))
    else $error("position or entry not latched");
  pos_speed_latch_a: assert property (
    (st_reg == rpsc_pkg::ST_CHECK) && (mode_reg == rpsc_pkg::SRC_POS_SPEED) && (chk_code == 16'h0000)
    |=> (TARGET_SPEED_OUT == $past(w6_s)) && (RAMP_ENTRY_OUT == rpsc_pkg::RAMP_ENTRY_FIXED))
    else $error("speed or fixed ramp entry not latched");
  table_done_a: assert property (
    (st_reg == rpsc_pkg::ST_IDLE) && req_ok && (src_reg == rpsc_pkg::SRC_TABLE)
    |-> ##2 POSITION_DONE_OUT && !SPEED_DONE_OUT)
    else $error("position done not raised two cycles after request");
  both_done_a: assert property (
    $rose(POSITION_DONE_OUT) && (mode_reg != rpsc_pkg::SRC_TABLE) |-> SPEED_DONE_OUT)
    else $error("speed done missing");
  respond_code_a: assert property (
    (st_reg == rpsc_pkg::ST_CHECK) |=> (RESPOND_ERROR_WORD_OUT == $past(chk_code))
    && (CMD_VALID_OUT == ($past(chk_code) == 16'h0000)))
    else $error("respond word does not match range check");
  done_release_a: assert property (
    (st_reg == rpsc_pkg::ST_DONE) && reqs_gone |=> !POSITION_DONE_OUT && !SPEED_DONE_OUT)
    else $error("done flag held after requests removed");
  volatile_clear_a: assert property (@(posedge MCLK_IN) disable iff (1'b0)
    !RST_N_IN |=> !CMD_VALID_OUT && (TARGET_POSITION_OUT == 32'h00000000))
    else $error("latched data survived reset");
  run_gate_a: assert property (
    FORWARD_RUN_OUT |-> $past(done_ok) && $past(CMD_VALID_OUT))
    else $error("run granted before done flags");

  table_cmd_c: cover property ($rose(POSITION_DONE_OUT) && (mode_reg == rpsc_pkg::SRC_TABLE));
  speed_cmd_c: cover property ($rose(SPEED_DONE_OUT) && (mode_reg == rpsc_pkg::SRC_POS_SPEED));
  range_err_c: cover property (ev[rpsc_pkg::EV_RANGE_ERR]);
  early_start_c: cover property (ev[rpsc_pkg::EV_EARLY_START]);
endmodule

/* File: bench/rpsc_master_model.sv */
// Purpose: fieldbus master model driving the remote words and request bits
// Assumes: one clock; every change lands just after a rising edge
// Notes: the millisecond settling wait is cut to a few cycles to keep runs short
`timescale 1ns/100ps
module rpsc_master_model #(
  parameter int SETTLE = 3
) (
  input wire logic clk_in,
  input wire logic pos_done_in,
  input wire logic spd_done_in,
  output logic [15:0] w4_out,
  output logic [15:0] w5_out,
  output logic [15:0] w6_out,
  output logic pos_req_out,
  output logic spd_req_out,
  output logic sel_out,
  output logic fwd_out,
  output logic rev_out
);
  // ==========
  // idle levels
  initial begin
    w4_out = 16'h0000;
    w5_out = 16'h0000;
    w6_out = 16'h0000;
    pos_req_out = 1'b0;
    spd_req_out = 1'b0;
    sel_out = 1'b0;
    fwd_out = 1'b0;
    rev_out = 1'b0;
  end
  // ==========
  // handshake tasks
  task automatic select(input logic s);
    @(posedge clk_in);
    sel_out <= s;
  endtask
  // words lead the requests by two cycles so the synchronisers see them whole
  task automatic command(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b,
                         input logic [15:0] c, output logic got);
    int n;
    n = 0;
    @(posedge clk_in);
    w4_out <= a;
    w5_out <= b;
    w6_out <= c;
    repeat (2) @(posedge clk_in);
    pos_req_out <= 1'b1;
    spd_req_out <= (m != 2'h0);
    @(posedge clk_in);
    while (!(pos_done_in && (m == 2'h0 || spd_done_in)) && n < 12) begin
      @(posedge clk_in);
      n++;
    end
    got = (n < 12);
    repeat (SETTLE) @(posedge clk_in);
  endtask
  task automatic start(input logic f, input logic r);
    @(posedge clk_in);
    fwd_out <= f;
    rev_out <= r;
  endtask
  // words past their hold time show the inverse, never a stale copy
  task automatic release_all(output logic dropped);
    int n;
    n = 0;
    @(posedge clk_in);
    pos_req_out <= 1'b0;
    spd_req_out <= 1'b0;
    fwd_out <= 1'b0;
    rev_out <= 1'b0;
    @(posedge clk_in);
    while ((pos_done_in || spd_done_in) && n < 12) begin
      @(posedge clk_in);
      n++;
    end
    dropped = (n < 12);
    w4_out <= ~w4_out;
    w5_out <= ~w5_out;
    w6_out <= ~w6_out;
  endtask
endmodule

/* File: bench/tb_rpsc_top.sv */
// Purpose: self-checking bench for the remote position/speed command block
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes: expected values follow the command rules and the package limits
`timescale 1ns/100ps
module tb_rpsc_top;
  logic clk, rst_n, wr, rd, got;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, tpos;
  logic [15:0] w4, w5, w6, resp, tent, tspd, tramp;
  logic preq, sreq, sel, fwd, rev, pdone, sdone, valid, frun, rrun, irq;
  int failures, tests_run;
  // mode, low word, high word, third word, expected respond word
  localparam logic [79:0] ERRS [6] = '{
    {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003},
    {16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0003},
    {16'h0001, 16'h0000, 16'h0100, 16'h0007, 16'h0030},
    {16'h0001, 16'h1234, 16'h0000, 16'h0000, 16'h0300},
    {16'h0002, 16'h0000, 16'h0000, 16'h1001, 16'h0300},
    {16'h0002, 16'h0000, 16'hFF00, 16'h0010, 16'h0030}};
  rpsc_top rpsc_top_i (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .CMD_WORD_POSITION_LOW_OR_ENTRY_IN(w4),
    .CMD_WORD_POSITION_HIGH_IN(w5), .CMD_WORD_SPEED_OR_ENTRY_IN(w6),
    .POSITION_CMD_REQUEST_IN(preq), .SPEED_CMD_REQUEST_IN(sreq),
    .SPECIFYING_SYSTEM_SELECT_IN(sel), .FORWARD_START_BIT_IN(fwd),
    .REVERSE_START_BIT_IN(rev), .POSITION_DONE_OUT(pdone), .SPEED_DONE_OUT(sdone),
    .RESPOND_ERROR_WORD_OUT(resp), .CMD_VALID_OUT(valid), .TARGET_POSITION_OUT(tpos),
    .TARGET_ENTRY_OUT(tent), .TARGET_SPEED_OUT(tspd), .RAMP_ENTRY_OUT(tramp),
    .FORWARD_RUN_OUT(frun), .REVERSE_RUN_OUT(rrun));
  rpsc_master_model #(.SETTLE(3)) rpsc_master_model_i (
    .clk_in(clk), .pos_done_in(pdone), .spd_done_in(sdone), .w4_out(w4), .w5_out(w5),
    .w6_out(w6), .pos_req_out(preq), .spd_req_out(sreq), .sel_out(sel), .fwd_out(fwd),
    .rev_out(rev));
  // ==========
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out();
  end
  // ==========
  // shared tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b,
                     input logic [15:0] c, input logic e);
    rpsc_master_model_i.command(m, a, b, c, got);
    chk(32'(got), 32'(e));
  endtask
  task automatic rel();
    rpsc_master_model_i.release_all(got);
    chk(32'(got), 32'h1);
  endtask
  task automatic run_chk(input logic f, input logic r, input logic [1:0] e);
    rpsc_master_model_i.start(f, r);
    wait_cyc(5);
    chk(32'({frun, rrun}), 32'(e));
  endtask
  // ==========
  // main sequence
  initial begin
    logic [79:0] e;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(rpsc_pkg::REG_CONFIG, 32'h0);
    rd_reg(rpsc_pkg::REG_SPEED_MAX, 32'h1000);
    rd_reg(rpsc_pkg::REG_ENTRY_MAX, 32'h00FF);
    rd_reg(rpsc_pkg::REG_IRQ_ENABLE, 32'h0);
    rd_reg(rpsc_pkg::REG_STATUS, 32'h0);
    rd_reg(8'h20, 32'h0);
    // refused while one station, reserved source or deselected
    rpsc_master_model_i.select(1'b1);
    cmd(2'h0, 16'h0005, 16'h0000, 16'h0000, 1'b0);
    rel();
    wr_reg(rpsc_pkg::REG_CONFIG, 32'h7);
    cmd(2'h0, 16'h0005, 16'h0000, 16'h0000, 1'b0);
    rel();
    rpsc_master_model_i.select(1'b0);
    wr_reg(rpsc_pkg::REG_CONFIG, 32'h4);
    cmd(2'h0, 16'h0005, 16'h0000, 16'h0000, 1'b0);
    rel();
    rpsc_master_model_i.select(1'b1);
    wr_reg(rpsc_pkg::REG_IRQ_ENABLE, 32'h7);
    cmd(2'h0, 16'h00FF, 16'h0000, 16'h0000, 1'b1);
    chk(32'({pdone, sdone, valid, resp}), 32'h50000);
    chk(32'({tent, tramp}), 32'h00FF00FF);
    chk(32'(irq), 32'h1);
    rd_reg(rpsc_pkg::REG_IRQ_STATUS, 32'h1);
    run_chk(1'b1, 1'b0, 2'h2);
    rel();
    chk(32'({pdone, sdone}), 32'h0);
    wr_reg(rpsc_pkg::REG_IRQ_CLEAR, 32'h7);
    rd_reg(rpsc_pkg::REG_IRQ_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    wr_reg(rpsc_pkg::REG_CONFIG, 32'h5);
    cmd(2'h1, 16'h3456, 16'h0012, 16'h0007, 1'b1);
    chk(32'({pdone, sdone}), 32'h3);
    chk(32'({tent, tramp}), 32'h00070007);
    rd_reg(rpsc_pkg::REG_POSITION, 32'h00123456);
    run_chk(1'b0, 1'b1, 2'h1);
    rel();
    chk(tpos, 32'h00123456);
    wr_reg(rpsc_pkg::REG_CONFIG, 32'h6);
    cmd(2'h2, 16'hFFF0, 16'hFFFF, 16'h1000, 1'b1);
    chk(tpos, 32'hFFFFFFF0);
    chk(32'({tspd, tramp}), 32'h10000001);
    rel();
    wr_reg(rpsc_pkg::REG_IRQ_CLEAR, 32'h7);
    for (int i = 0; i < 6; i++) begin
      e = ERRS[i];
      wr_reg(rpsc_pkg::REG_CONFIG, {29'h0, 1'b1, e[65:64]});
      cmd(e[65:64], e[63:48], e[47:32], e[31:16], 1'b1);
      chk(32'(resp), 32'(e[15:0]));
      chk(32'(valid), 32'h0);
      chk(tpos, 32'hFFFFFFF0);
      run_chk(1'b1, 1'b0, 2'h0);
      rel();
    end
    rd_reg(rpsc_pkg::REG_IRQ_STATUS, 32'h2);
    chk(32'(irq), 32'h1);
    wr_reg(rpsc_pkg::REG_IRQ_ENABLE, 32'h5);
    wait_cyc(2);
    chk(32'(irq), 32'h0);
    wr_reg(rpsc_pkg::REG_IRQ_CLEAR, 32'h7);
    wr_reg(rpsc_pkg::REG_CONFIG, 32'h4);
    run_chk(1'b1, 1'b0, 2'h0);
    rd_reg(rpsc_pkg::REG_IRQ_STATUS, 32'h4);
    rel();
    // latched data vanish on a reset in mid-command
    cmd(2'h0, 16'h0009, 16'h0000, 16'h0000, 1'b1);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(1);
    chk(tpos, 32'h0);
    chk(32'({tent, valid, pdone}), 32'h0);
    rd_reg(rpsc_pkg::REG_CONFIG, 32'h0);
    rel();
    close_out();
  end
endmodule
